// file: rtl/uart_pkg.sv
// constants shared by the serial control block and its bench
package uart_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_RELOAD = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [7:0] OFS_BIT = 8'h18;
   // serial_control bit positions
   localparam int B_HIGH = 7;
   localparam int B_LOW = 6;
   localparam int B_MP = 5;
   localparam int B_REN = 4;
   localparam int B_TB8 = 3;
   localparam int B_RB8 = 2;
   localparam int B_TI = 1;
   localparam int B_RI = 0;
   // configuration register bit positions
   localparam int C_VIEW = 0;
   localparam int C_DBL = 1;
   localparam int C_FAST = 2;
   localparam int C_SRC = 3;
   localparam int C_X2 = 4;
   // interrupt status bit positions
   localparam int S_TX = 0;
   localparam int S_RX = 1;
   localparam int S_FE = 2;
   // values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [4:0] CFG_RST = 5'h00;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [2:0] IRQ_RST = 3'h0;
   // half-bit periods in clocks or overflows, then divider, frame and bus constants
   localparam logic [7:0] HALF_M0 = 8'h06;
   localparam logic [7:0] HALF_M0_X2 = 8'h03;
   localparam logic [7:0] HALF_M2 = 8'h20;
   localparam logic [7:0] HALF_M2_DBL = 8'h10;
   localparam logic [7:0] HALF_VAR = 8'h10;
   localparam logic [7:0] HALF_VAR_DBL = 8'h08;
   localparam logic [7:0] PRE_SLOW = 8'h06;
   localparam logic [7:0] PRE_FAST = 8'h01;
   localparam logic [8:0] BRG_TOP = 9'h100;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP
   } frame_e;
endpackage : uart_pkg

// file: rtl/rate_divider.sv
// enable-pulse divider: one tick per period enabled cycles
`timescale 1ns/1ps
module rate_divider #(parameter int W = 8) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic en,
   input wire logic [W-1:0] period,
   output logic tick
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;

   // >= keeps a shortened period from wrapping the whole range
   always_comb begin
      tick = en && (count >= W'(period - 1'b1));
      next_count = count;
      if (en) begin
         next_count = tick ? '0 : W'(count + 1'b1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end
endmodule : rate_divider

// file: rtl/uart_serial_control.sv
// serial port control, framing and status behind an axi4-lite slave
//
// Contract
// [R1] invalid stop bit sets framing error; here set only while error view is selected
// [R2] framing error sticks until software clears
// [R3] bit 7 shows error or mode by view
// [R4] mode bits pick frame and bit rate
// [R5] multiproc gates rx done in modes 1-3
// [R6] receiver works only with receive enable
// [R7] modes 2,3 send tx ninth bit
// [R8] modes 2,3 load received ninth bit
// [R9] mode 1 stores stop; mode 0 unused
// [R10] tx done: bit 8 mode 0, else stop
// [R11] software clears done flags writing zero
// [R12] mode 0 rx done after eighth bit
// [R13] control clears at reset; bit writes
// [R14] generator clocks modes 1,3, optional 0
// [R15] error view moves rx done to stop
// [R16] generator rate from reload and speed
// [R17] doubler doubles rate in modes 1-3
// [R18] serial request while a done flag set
`timescale 1ns/1ps
module uart_serial_control (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_pin_i,
   output logic rx_pin_o,
   output logic rx_pin_oe,
   output logic tx_pin,
   output logic serial_irq,
   output logic irq
);
   import uart_pkg::*;

   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr, ar_addr_q;
   logic [7:0] w_data, next_w_data;
   logic w_lane0, next_w_lane0, next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_go, wr_en, ctrl_wr, rd_go, rd_stat, known_w, known_r;
   logic [7:0] serial_control, next_serial_control, view, wbyte;
   logic framing_error_flag, next_framing_error_flag;
   logic [4:0] config_q, next_config_q;
   logic [7:0] baud_reload_value, next_baud_reload_value;
   logic [7:0] rx_buffer, next_rx_buffer;
   logic [2:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
   logic mode_select_high, mode_select_low, multiproc_enable;
   logic receive_enable, tx_ninth_bit, rx_ninth_bit;
   logic tx_done_flag, rx_done_flag, error_view_select, baud_doubler;
   logic gen_fast_select, gen_for_shift_mode, double_speed_mode;
   logic m0, nine, pre_tick, ovf_tick, ht, bit_en;
   logic [7:0] half_period;
   frame_e tx_state, next_tx_state, rx_state, next_rx_state;
   logic tx_phase, next_tx_phase, m0_rx, next_m0_rx, ti_set, m0_done;
   logic [2:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
   logic [7:0] tx_shift, next_tx_shift, rx_shift, next_rx_shift;
   logic next_tx_pin, next_rx_pin_o, next_rx_pin_oe;
   logic rx_phase, next_rx_phase, rx_nine, next_rx_nine;
   logic rx_load, rx_bit8, fe_set, sample, frame_end;

   assign {mode_select_high, mode_select_low} = serial_control[7:6];
   assign multiproc_enable = serial_control[B_MP];
   assign receive_enable = serial_control[B_REN];
   assign tx_ninth_bit = serial_control[B_TB8];
   assign rx_ninth_bit = serial_control[B_RB8];
   assign tx_done_flag = serial_control[B_TI];
   assign rx_done_flag = serial_control[B_RI];
   assign error_view_select = config_q[C_VIEW];
   assign baud_doubler = config_q[C_DBL];
   assign gen_fast_select = config_q[C_FAST];
   assign gen_for_shift_mode = config_q[C_SRC];
   assign double_speed_mode = config_q[C_X2];
   assign m0 = !mode_select_high && !mode_select_low;
   assign nine = mode_select_high;

   ////////////////////////////////////////////////////////////////////////
   // bit-rate chain: prescaler, reload generator, half-bit divider
   rate_divider #(.W(8)) u_pre (.aclk(aclk), .aresetn(aresetn),
      .en(1'b1), .period(gen_fast_select ? PRE_FAST : PRE_SLOW),
      .tick(pre_tick)); // [R16]
   rate_divider #(.W(9)) u_brg (.aclk(aclk), .aresetn(aresetn),
      .en(pre_tick), .period(BRG_TOP - {1'b0, baud_reload_value}),
      .tick(ovf_tick)); // [R16]
   rate_divider #(.W(8)) u_half (.aclk(aclk), .aresetn(aresetn),
      .en(bit_en), .period(half_period), .tick(ht));

   // half a bit is 16 overflows, 8 with the doubler, so the 32 or 16 per bit are kept exactly
   always_comb begin
      bit_en = ovf_tick; // [R14]
      half_period = baud_doubler ? HALF_VAR_DBL : HALF_VAR; // [R17]
      if (m0 && !gen_for_shift_mode) begin
         bit_en = 1'b1;
         half_period = double_speed_mode ? HALF_M0_X2 : HALF_M0; // [R4]
      end else if (mode_select_high && !mode_select_low) begin
         bit_en = 1'b1;
         half_period = baud_doubler ? HALF_M2_DBL : HALF_M2; // [R4]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data taken in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign wr_en = wr_go && w_lane0;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign rd_stat = rd_go && s_axi_araddr == OFS_STAT;
   assign ctrl_wr = wr_en && (aw_addr == OFS_CTRL || aw_addr == OFS_BIT);
   assign known_w = aw_addr inside {OFS_CTRL, OFS_DATA, OFS_CFG,
      OFS_RELOAD, OFS_STAT, OFS_MASK, OFS_BIT};
   assign known_r = s_axi_araddr inside {OFS_CTRL, OFS_DATA, OFS_CFG,
      OFS_RELOAD, OFS_STAT, OFS_MASK};

   // the status read answers with the bits it clears
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_lane0 = w_lane0;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata[7:0];
         next_w_lane0 = s_axi_wstrb[0];
      end
      if (wr_go) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = known_w ? RESP_OKAY : RESP_SLVERR;
      end
      if (rd_go) begin
         next_rvalid = 1'b1;
         next_rresp = known_r ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_CTRL: next_rdata = {24'h0, view}; // [R3]
            OFS_DATA: next_rdata = {24'h0, rx_buffer};
            OFS_CFG: next_rdata = {27'h0, config_q};
            OFS_RELOAD: next_rdata = {24'h0, baud_reload_value};
            OFS_STAT: next_rdata = {29'h0, irq_status};
            OFS_MASK: next_rdata = {29'h0, irq_mask};
            default: next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h0;
         ar_addr_q <= 8'h00;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_lane0 <= next_w_lane0;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         ar_addr_q <= rd_go ? s_axi_araddr : ar_addr_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers: software writes, then hardware sets, so a set wins
   always_comb begin
      view = serial_control;
      view[B_HIGH] = error_view_select ? framing_error_flag
                                       : mode_select_high; // [R3]
      wbyte = w_data;
      if (aw_addr == OFS_BIT) begin
         wbyte = view;
         wbyte[w_data[2:0]] = w_data[3]; // [R13]
      end
      next_serial_control = serial_control;
      next_framing_error_flag = framing_error_flag;
      next_config_q = config_q;
      next_baud_reload_value = baud_reload_value;
      next_irq_mask = irq_mask;
      next_rx_buffer = rx_buffer;
      if (ctrl_wr) begin
         next_serial_control[6:0] = wbyte[6:0]; // [R11]
         if (error_view_select) begin
            next_framing_error_flag = wbyte[B_HIGH]; // [R2]
         end else begin
            next_serial_control[B_HIGH] = wbyte[B_HIGH];
         end
      end
      if (wr_en && aw_addr == OFS_CFG) next_config_q = w_data[4:0];
      if (wr_en && aw_addr == OFS_RELOAD) next_baud_reload_value = w_data;
      if (wr_en && aw_addr == OFS_MASK) next_irq_mask = w_data[2:0];
      if (ti_set) next_serial_control[B_TI] = 1'b1; // [R10]
      if (m0_done) begin
         next_serial_control[B_RI] = 1'b1; // [R12]
         next_rx_buffer = next_tx_shift; // eighth bit included
      end
      if (rx_load) begin
         next_serial_control[B_RI] = 1'b1;
         next_serial_control[B_RB8] = rx_bit8; // [R8] [R9]
         next_rx_buffer = rx_shift;
      end
      if (fe_set) next_framing_error_flag = 1'b1; // [R1]
      next_irq_status = (rd_stat ? IRQ_RST : irq_status)
                      | {fe_set, rx_load || m0_done, ti_set};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_control <= CTRL_RST; // [R13]
         framing_error_flag <= 1'b0;
         config_q <= CFG_RST;
         baud_reload_value <= RELOAD_RST;
         irq_mask <= IRQ_RST;
         irq_status <= IRQ_RST;
         rx_buffer <= 8'h00;
         serial_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         serial_control <= next_serial_control;
         framing_error_flag <= next_framing_error_flag;
         config_q <= next_config_q;
         baud_reload_value <= next_baud_reload_value;
         irq_mask <= next_irq_mask;
         irq_status <= next_irq_status;
         rx_buffer <= next_rx_buffer;
         serial_irq <= next_serial_control[B_TI]
                    || next_serial_control[B_RI]; // [R18]
         irq <= |(next_irq_status & next_irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmitter, also the mode 0 shifter in both directions
   always_comb begin
      next_tx_state = tx_state;
      next_tx_phase = tx_phase;
      next_tx_cnt = tx_cnt;
      next_tx_shift = tx_shift;
      next_m0_rx = m0_rx;
      ti_set = 1'b0;
      m0_done = 1'b0;
      case (tx_state)
         ST_IDLE: begin
            next_tx_phase = 1'b0;
            next_tx_cnt = 3'h0;
            if (wr_en && aw_addr == OFS_DATA) begin
               next_tx_shift = w_data;
               next_m0_rx = 1'b0;
               next_tx_state = m0 ? ST_DATA : ST_START;
            end else if (m0 && receive_enable && !rx_done_flag) begin
               next_m0_rx = 1'b1; // [R6]
               next_tx_state = ST_DATA;
            end
         end
         default: begin
            if (ht) begin
               next_tx_phase = !tx_phase;
               if (tx_phase) begin
                  case (tx_state)
                     ST_START: next_tx_state = ST_DATA;
                     ST_DATA: begin
                        next_tx_shift = {m0_rx && rx_pin_i, tx_shift[7:1]};
                        next_tx_cnt = 3'(tx_cnt + 1'b1);
                        if (tx_cnt == LAST_BIT) begin
                           if (m0) begin
                              next_tx_state = ST_IDLE;
                              ti_set = !m0_rx; // [R10]
                              m0_done = m0_rx && receive_enable; // [R12]
                           end else begin
                              next_tx_state = nine ? ST_NINTH : ST_STOP;
                              ti_set = !nine; // [R10]
                           end
                        end
                     end
                     ST_NINTH: begin
                        next_tx_state = ST_STOP;
                        ti_set = 1'b1; // [R10]
                     end
                     default: next_tx_state = ST_IDLE;
                  endcase
               end
            end
         end
      endcase
      // mode 0 puts the shift clock on the transmit pin, low first half
      next_rx_pin_oe = m0 && next_tx_state == ST_DATA && !next_m0_rx;
      next_rx_pin_o = next_tx_shift[0];
      case (next_tx_state)
         ST_START: next_tx_pin = 1'b0;
         ST_DATA: next_tx_pin = m0 ? next_tx_phase : next_tx_shift[0];
         ST_NINTH: next_tx_pin = tx_ninth_bit; // [R7]
         default: next_tx_pin = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state <= ST_IDLE;
         tx_phase <= 1'b0;
         tx_cnt <= 3'h0;
         tx_shift <= 8'h00;
         m0_rx <= 1'b0;
         tx_pin <= 1'b1;
         rx_pin_o <= 1'b0;
         rx_pin_oe <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         tx_phase <= next_tx_phase;
         tx_cnt <= next_tx_cnt;
         tx_shift <= next_tx_shift;
         m0_rx <= next_m0_rx;
         tx_pin <= next_tx_pin;
         rx_pin_o <= next_rx_pin_o;
         rx_pin_oe <= next_rx_pin_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // asynchronous receiver: start seen on a half tick, sampled mid-bit
   assign sample = ht && !rx_phase;
   always_comb begin
      next_rx_state = rx_state;
      next_rx_phase = ht ? !rx_phase : rx_phase;
      next_rx_cnt = rx_cnt;
      next_rx_shift = rx_shift;
      next_rx_nine = rx_nine;
      frame_end = 1'b0;
      rx_bit8 = rx_pin_i; // [R9]
      fe_set = 1'b0;
      case (rx_state)
         ST_IDLE: begin
            next_rx_phase = 1'b0;
            next_rx_cnt = 3'h0;
            if (ht && !m0 && receive_enable && !rx_pin_i) begin
               next_rx_state = ST_START;
            end
         end
         ST_START: if (sample) begin
            next_rx_state = rx_pin_i ? ST_IDLE : ST_DATA; // false start
         end
         ST_DATA: if (sample) begin
            next_rx_shift = {rx_pin_i, rx_shift[7:1]};
            next_rx_cnt = 3'(rx_cnt + 1'b1);
            if (rx_cnt == LAST_BIT) begin
               next_rx_state = nine ? ST_NINTH : ST_STOP;
            end
         end
         ST_NINTH: if (sample) begin
            next_rx_nine = rx_pin_i;
            next_rx_state = ST_STOP;
            frame_end = !error_view_select; // [R15]
         end
         ST_STOP: if (sample) begin
            next_rx_state = ST_IDLE;
            frame_end = error_view_select || !nine; // [R15]
            fe_set = error_view_select && !rx_pin_i; // [R1]
         end
         default: next_rx_state = ST_IDLE;
      endcase
      if (nine) rx_bit8 = rx_state == ST_NINTH ? rx_pin_i : rx_nine; // [R8]
      // a full buffer is kept; multiproc passes only frames with the ninth bit set, in mode 1 a high stop bit
      rx_load = frame_end && !rx_done_flag && receive_enable
             && (!multiproc_enable || rx_bit8); // [R5]
      if (!receive_enable || m0) next_rx_state = ST_IDLE; // [R6]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state <= ST_IDLE;
         rx_phase <= 1'b0;
         rx_cnt <= 3'h0;
         rx_shift <= 8'h00;
         rx_nine <= 1'b0;
      end else begin
         rx_state <= next_rx_state;
         rx_phase <= next_rx_phase;
         rx_cnt <= next_rx_cnt;
         rx_shift <= next_rx_shift;
         rx_nine <= next_rx_nine;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_bad_stop;
      rx_state == ST_STOP && sample && error_view_select && !rx_pin_i;
   endsequence
   sequence s_ninth_end;
      tx_state == ST_NINTH && ht && tx_phase;
   endsequence
   a_fe_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
      s_bad_stop |=> framing_error_flag)
      else $error("framing error not set");
   a_fe_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
      framing_error_flag && !ctrl_wr |=> framing_error_flag)
      else $error("framing error lost");
   a_bit7_view: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
      rd_go && s_axi_araddr == OFS_CTRL |=> s_axi_rdata[7] ==
      $past(error_view_select ? framing_error_flag : mode_select_high))
      else $error("bit 7 view wrong");
   a_ren_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
      !receive_enable |-> !rx_load && !m0_done)
      else $error("reception while disabled");
   a_ninth_out: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
      tx_state == ST_NINTH |-> tx_pin == $past(tx_ninth_bit))
      else $error("ninth bit not sent");
   a_rb8_load: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
      rx_load |=> rx_ninth_bit == $past(rx_bit8))
      else $error("ninth bit not stored");
   a_rb8_m0: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
      m0 && !ctrl_wr && rx_state == ST_IDLE |=> $stable(rx_ninth_bit))
      else $error("ninth bit moved in mode 0");
   a_ti_stop: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      s_ninth_end |=> tx_done_flag ##1 tx_state == ST_STOP [*2])
      else $error("tx done not at stop");
   // the buffer must hold the shifter after its eighth shift
   a_ri_m0: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      m0_done |=> rx_done_flag && rx_buffer == tx_shift)
      else $error("mode 0 rx done missing");
   a_reset_clear: assert property (@(posedge aclk) // [R13]
      $rose(aresetn) |-> serial_control == CTRL_RST
      && !framing_error_flag)
      else $error("control not cleared");
   a_serial_req: assert property (@(posedge aclk) // [R18]
      disable iff (!aresetn) rx_done_flag && !ctrl_wr |=> serial_irq)
      else $error("serial request missing");
endmodule : uart_serial_control

// file: dv/serial_peer.sv
// remote serial peer: sends frames to the block and captures its frames
`timescale 1ns/1ps
module serial_peer (
   input wire logic aclk,
   input wire logic tx_pin,
   input wire logic rx_pin_o,
   input wire logic rx_pin_oe,
   input wire logic [7:0] bit_clks,
   output logic line
);
   logic [9:0] frame;
   logic [7:0] m0_byte;
   // shift-register mode: data stands still at the clock's rising edge
   always @(posedge tx_pin) begin
      if (rx_pin_oe) m0_byte <= {rx_pin_o, m0_byte[7:1]};
   end
   // idle line is the mark level
   initial line = 1'b1;
   // start, data lsb first, ninth or stop, then one more bit
   task automatic send(input logic [7:0] d, input logic nine_en,
      input logic nine, input logic stop);
      logic [10:0] bits;
      bits = nine_en ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line <= bits[i];
         repeat (bit_clks) @(posedge aclk);
      end
      line <= 1'b1;
      repeat (bit_clks) @(posedge aclk);
   endtask : send
   // sample each bit after the start bit in its middle, far from the edges
   initial begin
      forever begin
         @(negedge tx_pin);
         repeat (bit_clks / 2) @(posedge aclk);
         for (int i = 0; i < 10; i++) begin
            repeat (bit_clks) @(posedge aclk);
            frame[i] = tx_pin;
         end
      end
   end
endmodule : serial_peer

// file: dv/testbench.sv
// self-checking bench for the serial control block
`timescale 1ns/1ps
module testbench;
   import uart_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, bit_clks = 8'h40;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd_val;
   logic [1:0] bresp, rresp, resp;
   logic awready, wready, bvalid, arready, rvalid, line, tx_pin;
   logic serial_irq, irq, rx_pin_o, rx_pin_oe;
   int error_cnt = 0, n_tests = 0;
   uart_serial_control DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_pin_i(line),
      .rx_pin_o(rx_pin_o), .rx_pin_oe(rx_pin_oe), .tx_pin(tx_pin),
      .serial_irq(serial_irq), .irq(irq));
   serial_peer peer (.aclk(aclk), .tx_pin(tx_pin), .bit_clks(bit_clks),
      .rx_pin_o(rx_pin_o), .rx_pin_oe(rx_pin_oe), .line(line));
   // 200 MHz clock
   always #2.5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // a wait that used its whole bound ends the run
   task automatic limit(input int n);
      if (n >= 2000) begin
         error_cnt++;
         wrap_up();
      end
   endtask : limit
   // each channel released at the edge that takes it; one idle edge after
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      resp = bresp;
      limit(n);
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      rd_val = rdata;
      resp = rresp;
      limit(n);
      @(posedge aclk);
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_val, exp);
   endtask : rchk
   // bounded wait for the serial request
   task automatic wait_irq;
      int n;
      for (n = 0; n < 2000 && serial_irq !== 1'b1; n++) @(posedge aclk);
      limit(n);
   endtask : wait_irq
   ////////////////////////////////////////////////////////////////////////
   // reset, mode 2 traffic, mode 1 framing, mode 3, then mode 0
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(OFS_CTRL, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rd(8'h1C);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(OFS_CTRL, 32'h98);
      wr(OFS_MASK, 32'h1);
      wr(OFS_DATA, 32'hA5);
      wait_irq();
      rchk(OFS_CTRL, 32'h9A);
      chk({31'h0, irq}, 32'h1);
      repeat (128) @(posedge aclk);
      chk({22'h0, peer.frame}, 32'h3A5);
      rchk(OFS_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_CTRL, 32'h98);
      chk({31'h0, serial_irq}, 32'h0);
      peer.send(8'h3C, 1'b1, 1'b0, 1'b1);
      rchk(OFS_CTRL, 32'h99);
      rchk(OFS_DATA, 32'h3C);
      wr(OFS_CTRL, 32'h98);
      peer.send(8'hC3, 1'b1, 1'b1, 1'b1);
      rchk(OFS_CTRL, 32'h9D);
      wr(OFS_CTRL, 32'h8C);
      peer.send(8'h55, 1'b1, 1'b0, 1'b1);
      rchk(OFS_CTRL, 32'h8C);
      wr(OFS_CTRL, 32'hBC);
      peer.send(8'h66, 1'b1, 1'b0, 1'b1);
      rchk(OFS_CTRL, 32'hBC);
      peer.send(8'h77, 1'b1, 1'b1, 1'b1);
      rchk(OFS_CTRL, 32'hBD);
      rchk(OFS_DATA, 32'h77);
      // mode bits written before the error view hides bit 7
      bit_clks <= 8'h20;
      wr(OFS_CTRL, 32'h40);
      wr(OFS_CFG, 32'h05);
      wr(OFS_RELOAD, 32'hFF);
      wr(OFS_BIT, 32'h0C);
      rchk(OFS_CTRL, 32'h50);
      peer.send(8'h81, 1'b0, 1'b0, 1'b0);
      rchk(OFS_CTRL, 32'hD1);
      wr(OFS_CTRL, 32'hD0);
      peer.send(8'h18, 1'b0, 1'b0, 1'b1);
      rchk(OFS_CTRL, 32'hD5);
      // slow prescaler with the doubler: 96 clocks a bit
      bit_clks <= 8'h60;
      wr(OFS_CFG, 32'h02);
      rchk(OFS_CTRL, 32'h55);
      wr(OFS_CTRL, 32'hD0);
      peer.send(8'h5A, 1'b1, 1'b1, 1'b1);
      rchk(OFS_CTRL, 32'hD5);
      rchk(OFS_DATA, 32'h5A);
      // shift-register mode: send, then take in the idle line
      wr(OFS_CTRL, 32'h00);
      wr(OFS_DATA, 32'h96);
      wait_irq();
      rchk(OFS_CTRL, 32'h02);
      chk({24'h0, peer.m0_byte}, 32'h96);
      wr(OFS_CTRL, 32'h10);
      wait_irq();
      rchk(OFS_CTRL, 32'h11);
      rchk(OFS_DATA, 32'hFF);
      wrap_up();
   end
endmodule : testbench
